// >>> common/srbc_map.svh
`ifndef SRBC_MAP_SVH
`define SRBC_MAP_SVH
// Operation
// - Noise-wait set: count oscillator periods, resample
// - Resample low: drop event, no interrupt/reset
// - Noise-wait clear: report assertion immediately
// - Wait count bits 15:2, reset 0x1FFF
// - Action select 1 resets, 0 interrupts
// - Brown-out raw bit set on every report (immediate hit or confirmed resample)
// - Brown-out interrupt needs mask and action clear
// - Regulator code accepts only listed codes
// - Reset-control writes ignore absent peripherals
// - Control 0: PWM bit 20, watchdog bit 3
// - Control 1: comparators, timers, serial units
// - Control 2: five I/O ports, bits 4:0
// - Raw status read-only, seven event bits
// - Mask bits 6:0 read-write, upper bits zero
// - Masked set raw bit raises interrupt
// - Masked status is raw AND mask
// - Clear write clears masked and raw bit

// ==========================================================
// Register offsets (byte addresses)
`define SRBC_OFF_BCTL   8'h30
`define SRBC_OFF_VCTL   8'h34
`define SRBC_OFF_PRST0  8'h40
`define SRBC_OFF_PRST1  8'h44
`define SRBC_OFF_PRST2  8'h48
`define SRBC_OFF_RAW    8'h50
`define SRBC_OFF_MASK   8'h54
`define SRBC_OFF_CLR    8'h58

// ==========================================================
// Field positions
`define SRBC_NW_BIT     0
`define SRBC_ACT_BIT    1
`define SRBC_BO_BIT     1

// ==========================================================
// Reset values and writable masks
`define SRBC_BCTL_RST   16'h7FFD
`define SRBC_REGULATOR_ADJUST_CODE_RST   6'h00
`define SRBC_RW0_MASK   32'h0010_0008
`define SRBC_RW1_MASK   32'h0707_1113
`define SRBC_RW2_MASK   32'h0000_001F
`define SRBC_EVT_MASK   7'h7F

// ==========================================================
// Regulator code limits
`define SRBC_REGULATOR_ADJUST_CODE_LOMAX 6'h05
`define SRBC_REGULATOR_ADJUST_CODE_HIMIN 6'h1B
`define SRBC_REGULATOR_ADJUST_CODE_HIMAX 6'h1F
`endif

// >>> common/srbc_pkg.sv
package srbc_pkg;
  // Brown-out filter states
  typedef enum logic [1:0] {
    SRBC_IDLE,
    SRBC_WAIT,
    SRBC_HOLD
  } srbc_bo_st_t;

  // Brown-out control word as stored
  typedef struct packed {
    logic [13:0] wait_cnt;
    logic        act_sel;
    logic        noise_wait;
  } srbc_bctl_t;

  // Monitor inputs, event order matches raw status
  typedef struct packed {
    logic [6:0] evt;
    logic       osc_tick;
  } srbc_mon_t;
endpackage

// >>> hw/srbc_top.sv
`timescale 1ns/1ns
`include "srbc_map.svh"

module srbc_top
  import srbc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // Capability words
  input  wire logic [31:0] CAP1,
  input  wire logic [31:0] CAP2,
  input  wire logic [31:0] CAP4,
  // Analog monitors
  input  wire logic        BOD_OUT,
  input  wire logic        OSC_TICK,
  input  wire logic        PLL_LOCK,
  input  wire logic        CUR_LIMIT,
  input  wire logic        INTERNAL_OSCILLATOR_FAULT,
  input  wire logic        MOSC_FAULT,
  input  wire logic        REG_UNREG,
  input  wire logic        PLL_FAULT,
  // Outputs to the system
  output logic             IRQ,
  output logic             BROWNOUT_RESET,
  output logic      [5:0]  REGULATOR_ADJUST_CODE_CODE,
  output logic      [31:0] PRST0,
  output logic      [31:0] PRST1,
  output logic      [31:0] PRST2
);

  // ========================================================
  // Input synchronisers
  srbc_mon_t  mon_pins;
  srbc_mon_t  mon_s1_r;
  srbc_mon_t  mon_s2_r;
  logic       tick_d_r;
  logic       tick;
  logic       bod;

  // Bit 1 carries the detector; its raw bit comes from the filter
  assign mon_pins = '{evt: {PLL_LOCK, CUR_LIMIT, INTERNAL_OSCILLATOR_FAULT,
                            MOSC_FAULT, REG_UNREG, BOD_OUT,
                            PLL_FAULT},
                      osc_tick: OSC_TICK};

  // Two stages before anything looks at a pin
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mon_s1_r <= '0;
      mon_s2_r <= '0;
    end else begin
      mon_s1_r <= mon_pins;
      mon_s2_r <= mon_s1_r;
    end
  end

  // Oscillator edge found on the settled copy only
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= mon_s2_r.osc_tick;
    end
  end

  assign tick = mon_s2_r.osc_tick & ~tick_d_r;
  assign bod  = mon_s2_r.evt[`SRBC_BO_BIT];

  // ========================================================
  // Register decode
  logic       wr_bctl;
  logic       wr_vctl;
  logic       wr_p0;
  logic       wr_p1;
  logic       wr_p2;
  logic       wr_mask;
  logic       wr_clr;

  assign wr_bctl = WR && (ADDR == `SRBC_OFF_BCTL);
  assign wr_vctl = WR && (ADDR == `SRBC_OFF_VCTL);
  assign wr_p0   = WR && (ADDR == `SRBC_OFF_PRST0);
  assign wr_p1   = WR && (ADDR == `SRBC_OFF_PRST1);
  assign wr_p2   = WR && (ADDR == `SRBC_OFF_PRST2);
  assign wr_mask = WR && (ADDR == `SRBC_OFF_MASK);
  assign wr_clr  = WR && (ADDR == `SRBC_OFF_CLR);

  // ========================================================
  // Brown-out control word
  srbc_bctl_t bctl_r;

  // Count field, action select and noise wait all writable
  always_ff @(posedge CLK) begin
    if (SRST) begin
      bctl_r <= `SRBC_BCTL_RST;
    end else if (wr_bctl) begin
      bctl_r <= WDATA[15:0];
    end
  end

  // ========================================================
  // Regulator adjust
  logic [5:0] regulator_adjust_code_r;
  logic       regulator_adjust_code_ok;

  // Reserved codes never reach the regulator
  assign regulator_adjust_code_ok = (WDATA[5:0] <= `SRBC_REGULATOR_ADJUST_CODE_LOMAX) ||
                   ((WDATA[5:0] >= `SRBC_REGULATOR_ADJUST_CODE_HIMIN) &&
                    (WDATA[5:0] <= `SRBC_REGULATOR_ADJUST_CODE_HIMAX));

  always_ff @(posedge CLK) begin
    if (SRST) begin
      regulator_adjust_code_r <= `SRBC_REGULATOR_ADJUST_CODE_RST;
    end else if (wr_vctl && regulator_adjust_code_ok) begin
      regulator_adjust_code_r <= WDATA[5:0];
    end
  end

  // ========================================================
  // Peripheral reset controls
  logic [31:0] prst0_r;
  logic [31:0] prst1_r;
  logic [31:0] prst2_r;

  // Absent units keep their bit at zero, whatever is written
  always_ff @(posedge CLK) begin
    if (SRST) begin
      prst0_r <= '0;
    end else if (wr_p0) begin
      prst0_r <= WDATA & CAP1 & `SRBC_RW0_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      prst1_r <= '0;
    end else if (wr_p1) begin
      prst1_r <= WDATA & CAP2 & `SRBC_RW1_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      prst2_r <= '0;
    end else if (wr_p2) begin
      prst2_r <= WDATA & CAP4 & `SRBC_RW2_MASK;
    end
  end

  // Reset lines are the stored bits, held while they read 1
  assign PRST0 = prst0_r;
  assign PRST1 = prst1_r;
  assign PRST2 = prst2_r;

  // ========================================================
  // Brown-out filter
  srbc_bo_st_t bo_st_r;
  logic [13:0] bo_cnt_r;
  logic        bo_rpt;
  logic        bo_rpt_r;

  // A report is either an unfiltered hit or a confirmed resample
  assign bo_rpt = (bo_st_r == SRBC_IDLE && bod &&
                   !bctl_r.noise_wait) ||
                  (bo_st_r == SRBC_WAIT && bo_cnt_r == 14'h0000 &&
                   bod);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      bo_st_r <= SRBC_IDLE;
    end else begin
      case (bo_st_r)
        SRBC_IDLE: begin
          if (bod && bctl_r.noise_wait) begin
            bo_st_r <= SRBC_WAIT;
          end else if (bod) begin
            bo_st_r <= SRBC_HOLD;
          end
        end
        SRBC_WAIT: begin
          if (bo_cnt_r == 14'h0000) begin
            // A low resample means noise: back to idle silently
            bo_st_r <= bod ? SRBC_HOLD : SRBC_IDLE;
          end
        end
        SRBC_HOLD: begin
          // Rearm only once the detector has let go
          if (!bod) begin
            bo_st_r <= SRBC_IDLE;
          end
        end
        default: begin
          bo_st_r <= SRBC_IDLE;
        end
      endcase
    end
  end

  // Period counter, loaded on entry and stepped per oscillator edge
  always_ff @(posedge CLK) begin
    if (SRST) begin
      bo_cnt_r <= '0;
    end else if (bo_st_r == SRBC_IDLE) begin
      bo_cnt_r <= bctl_r.wait_cnt;
    end else if (bo_st_r == SRBC_WAIT && tick &&
                 bo_cnt_r != 14'h0000) begin
      bo_cnt_r <= bo_cnt_r - 14'h0001;
    end
  end

  // Report pulse and the reset route
  always_ff @(posedge CLK) begin
    if (SRST) begin
      bo_rpt_r       <= 1'b0;
      BROWNOUT_RESET <= 1'b0;
    end else begin
      bo_rpt_r       <= bo_rpt;
      BROWNOUT_RESET <= bo_rpt && bctl_r.act_sel;
    end
  end

  // ========================================================
  // Event status, mask and interrupt
  logic [6:0] raw_r;
  logic [6:0] mask_r;
  logic [6:0] set_v;
  logic [6:0] clr_v;
  logic [6:0] gate;
  logic [6:0] mstat;

  // Monitors set their bit; the detector bit needs a report
  always_comb begin
    set_v = mon_s2_r.evt;
    set_v[`SRBC_BO_BIT] = bo_rpt;
    clr_v = wr_clr ? WDATA[6:0] : 7'h00;
  end

  // Set beats clear so no event slips through a clear write
  always_ff @(posedge CLK) begin
    if (SRST) begin
      raw_r <= '0;
    end else begin
      raw_r <= (raw_r & ~clr_v) | set_v;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      mask_r <= '0;
    end else if (wr_mask) begin
      mask_r <= WDATA[6:0] & `SRBC_EVT_MASK;
    end
  end

  // Brown-out routed to reset never interrupts
  always_comb begin
    gate = `SRBC_EVT_MASK;
    gate[`SRBC_BO_BIT] = !bctl_r.act_sel;
  end

  assign mstat = raw_r & mask_r;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(mstat & gate);
    end
  end

  // ========================================================
  // Read port, data in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SRST || !RD) begin
      RDATA <= '0;
    end else begin
      case (ADDR)
        `SRBC_OFF_BCTL:  RDATA <= {16'h0000, bctl_r};
        `SRBC_OFF_VCTL:  RDATA <= {26'h0, regulator_adjust_code_r};
        `SRBC_OFF_PRST0: RDATA <= prst0_r;
        `SRBC_OFF_PRST1: RDATA <= prst1_r;
        `SRBC_OFF_PRST2: RDATA <= prst2_r;
        `SRBC_OFF_RAW:   RDATA <= {25'h0, raw_r};
        `SRBC_OFF_MASK:  RDATA <= {25'h0, mask_r};
        `SRBC_OFF_CLR:   RDATA <= {25'h0, mstat};
        default:         RDATA <= '0;
      endcase
    end
  end

  assign REGULATOR_ADJUST_CODE_CODE = regulator_adjust_code_r;

  // ========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence seq_hit_wait;
    bo_st_r == SRBC_IDLE && bod && bctl_r.noise_wait;
  endsequence

  sequence seq_resample_low;
    bo_st_r == SRBC_WAIT && bo_cnt_r == 14'h0000 && !bod;
  endsequence

  sequence seq_hit_now;
    bo_st_r == SRBC_IDLE && bod && !bctl_r.noise_wait;
  endsequence

  // Entry to wait holds the programmed count
  chk_wait_entry: assert property (
    seq_hit_wait |=> bo_st_r == SRBC_WAIT &&
                     bo_cnt_r == $past(bctl_r.wait_cnt))
    else $error("wait entry wrong");

  // Noise gives no report and no reset
  chk_noise_drop: assert property (
    seq_resample_low |=> bo_st_r == SRBC_IDLE && !bo_rpt_r &&
                         !BROWNOUT_RESET)
    else $error("noise was reported");

  // Unfiltered hit reports next cycle
  chk_imm_report: assert property (
    seq_hit_now |=> bo_rpt_r)
    else $error("immediate report missing");

  // Reset path follows action select
  chk_reset_route: assert property (
    bo_rpt |=> BROWNOUT_RESET == $past(bctl_r.act_sel))
    else $error("reset routing wrong");

  // Report sets raw bit one cycle later
  chk_raw_set: assert property (
    bo_rpt |=> raw_r[`SRBC_BO_BIT])
    else $error("brown-out raw not set");

  // Brown-out alone with reset route stays quiet
  chk_bo_gate: assert property (
    mstat == 7'h02 && bctl_r.act_sel |=> !IRQ)
    else $error("irq despite reset route");

  // Regulator code always legal
  chk_regulator_adjust_code_legal: assert property (
    (REGULATOR_ADJUST_CODE_CODE <= 6'h05) ||
    (REGULATOR_ADJUST_CODE_CODE >= 6'h1B && REGULATOR_ADJUST_CODE_CODE <= 6'h1F))
    else $error("reserved regulator code");

  // Absent or reserved bits never set
  chk_cap_gate: assert property (
    ((PRST0 & ~(CAP1 & 32'h0010_0008)) == 32'h0) &&
    ((PRST1 & ~(CAP2 & 32'h0707_1113)) == 32'h0) &&
    ((PRST2 & ~(CAP4 & 32'h0000_001F)) == 32'h0))
    else $error("reset bit for absent unit");

  // Enabled raw event raises interrupt
  chk_irq_follow: assert property (
    |(raw_r & mask_r & gate) |=> IRQ)
    else $error("interrupt missing");

  // Masked-off events do not interrupt
  chk_irq_quiet: assert property (
    (raw_r & mask_r) == 7'h00 |=> !IRQ)
    else $error("spurious interrupt");

  // Clear without new event empties the bit
  chk_clear_raw: assert property (
    wr_clr && WDATA[0] && !set_v[0] |=> !raw_r[0])
    else $error("clear did not act");

  // Held detector keeps the filter parked
  chk_hold_park: assert property (
    bo_st_r == SRBC_HOLD && bod |=> bo_st_r == SRBC_HOLD)
    else $error("rearmed while detector high");

endmodule

// >>> verif/srbc_bod_model.sv
`timescale 1ns/1ns

// ==========================================================
// Brown-out detector and internal oscillator model
module srbc_bod_model (
  // Supply level requested by the bench
  input  wire logic bod_lvl,
  // Analog outputs
  output logic      bod_out,
  output logic      osc_tick
);
  // Oscillator runs free, out of phase with the bus clock
  initial begin
    osc_tick = 1'b0;
    #37;
    forever #170 osc_tick = ~osc_tick;
  end

  // Comparator output follows the supply level
  assign bod_out = bod_lvl;
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ns
`include "srbc_map.svh"

module tb;
  // ==========================================================
  // Signals
  logic        clk, srst, wr, rd, bod_lvl, bod_out, osc_tick;
  logic        irq, bo_rst, rd_seen;
  logic [7:0]  addr;
  logic [6:0]  ev;
  logic [5:0]  regulator_adjust_code, vexp;
  logic [31:0] wdata, rdata, cap1, cap2, cap4, seed, b, irqw;
  logic [31:0] prst0, prst1, prst2;
  logic [31:0] exp_q[$];
  int          err_count, num_checks, cyc, rst_cnt;

  assign irqw = {31'h0, irq};

  // Clock, 100 ns period
  always #50 clk = ~clk;

  srbc_top u_srbc_top (
    .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CAP1(cap1), .CAP2(cap2), .CAP4(cap4),
    .BOD_OUT(bod_out), .OSC_TICK(osc_tick), .PLL_LOCK(ev[6]),
    .CUR_LIMIT(ev[5]), .INTERNAL_OSCILLATOR_FAULT(ev[4]), .MOSC_FAULT(ev[3]),
    .REG_UNREG(ev[2]), .PLL_FAULT(ev[0]), .IRQ(irq),
    .BROWNOUT_RESET(bo_rst), .REGULATOR_ADJUST_CODE_CODE(regulator_adjust_code), .PRST0(prst0),
    .PRST1(prst1), .PRST2(prst2)
  );

  srbc_bod_model u_srbc_bod_model (
    .bod_lvl(bod_lvl), .bod_out(bod_out), .osc_tick(osc_tick)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One strobe cycle, then one idle cycle so strobes never re-assert
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==========================================================
  // Read-data monitor, reset pulse counter and timeout
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      chk(rdata, exp_q.pop_front());
    end
    rd_seen <= rd;
    if (bo_rst === 1'b1) rst_cnt++;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    clk = 0; srst = 1; wr = 0; rd = 0; addr = 0; wdata = 0;
    ev = 0; bod_lvl = 0; rd_seen = 0;
    seed = lfsr(32'h7ABA6743);
    cap1 = seed;
    seed = lfsr(seed);
    cap2 = seed;
    seed = lfsr(seed);
    cap4 = seed;
    wt(3);
    srst <= 1'b0;
    wt(1);
    // Reset values, unmapped address reads zero
    rdx(`SRBC_OFF_BCTL, {16'h0, `SRBC_BCTL_RST});
    rdx(`SRBC_OFF_PRST0, 32'h0);
    rdx(`SRBC_OFF_PRST1, 32'h0);
    rdx(`SRBC_OFF_PRST2, 32'h0);
    rdx(`SRBC_OFF_RAW, 32'h0);
    rdx(`SRBC_OFF_MASK, 32'h0);
    rdx(`SRBC_OFF_VCTL, 32'h0);
    rdx(8'h10, 32'h0);
    $display("test reset values done");
    // Reset controls gated by random capability words
    acc(1'b1, `SRBC_OFF_PRST0, 32'hFFFF_FFFF);
    acc(1'b1, `SRBC_OFF_PRST1, 32'hFFFF_FFFF);
    seed = lfsr(seed);
    acc(1'b1, `SRBC_OFF_PRST2, seed);
    rdx(`SRBC_OFF_PRST0, `SRBC_RW0_MASK & cap1);
    rdx(`SRBC_OFF_PRST1, `SRBC_RW1_MASK & cap2);
    rdx(`SRBC_OFF_PRST2, `SRBC_RW2_MASK & cap4 & seed);
    chk(prst0, `SRBC_RW0_MASK & cap1);
    chk(prst1, `SRBC_RW1_MASK & cap2);
    chk(prst2, `SRBC_RW2_MASK & cap4 & seed);
    acc(1'b1, `SRBC_OFF_PRST1, 32'h0);
    chk(prst1, 32'h0);
    $display("test reset controls done");
    // Every regulator code, reserved ones leave the setting alone
    vexp = 6'h00;
    for (int c = 0; c < 64; c++) begin
      acc(1'b1, `SRBC_OFF_VCTL, 32'(c));
      if (c[5:0] <= 6'h05 || (c[5:0] >= 6'h1B && c[5:0] <= 6'h1F)) begin
        vexp = c[5:0];
      end
      chk({26'h0, regulator_adjust_code}, {26'h0, vexp});
    end
    rdx(`SRBC_OFF_VCTL, {26'h0, vexp});
    $display("test regulator done");
    // System events: raw, mask, interrupt, clear
    acc(1'b1, `SRBC_OFF_MASK, 32'hFFFF_FFFF);
    rdx(`SRBC_OFF_MASK, 32'h0000_007F);
    acc(1'b1, `SRBC_OFF_MASK, 32'h0);
    for (int i = 0; i < 7; i++) begin
      if (i != 1) begin
        b = 32'h1 << i;
        ev[i] <= 1'b1;
        wt(6);
        ev[i] <= 1'b0;
        wt(4);
        rdx(`SRBC_OFF_RAW, b);
        chk(irqw, 32'h0);
        acc(1'b1, `SRBC_OFF_MASK, b);
        wt(2);
        chk(irqw, 32'h1);
        rdx(`SRBC_OFF_CLR, b);
        acc(1'b1, `SRBC_OFF_CLR, b);
        wt(2);
        rdx(`SRBC_OFF_RAW, 32'h0);
        chk(irqw, 32'h0);
      end
    end
    $display("test events done");
    // Brown-out reported at once, as interrupt
    acc(1'b1, `SRBC_OFF_MASK, 32'h2);
    acc(1'b1, `SRBC_OFF_BCTL, 32'h0);
    bod_lvl <= 1'b1;
    wt(8);
    rdx(`SRBC_OFF_RAW, 32'h2);
    chk(irqw, 32'h1);
    chk(32'(rst_cnt), 32'h0);
    acc(1'b1, `SRBC_OFF_CLR, 32'h2);
    wt(8);
    rdx(`SRBC_OFF_RAW, 32'h0);
    bod_lvl <= 1'b0;
    wt(4);
    // Brown-out reported as reset
    acc(1'b1, `SRBC_OFF_BCTL, 32'h2);
    bod_lvl <= 1'b1;
    wt(8);
    rdx(`SRBC_OFF_RAW, 32'h2);
    chk(irqw, 32'h0);
    chk(32'(rst_cnt), 32'h1);
    bod_lvl <= 1'b0;
    acc(1'b1, `SRBC_OFF_CLR, 32'h2);
    // Noise filter, four oscillator periods
    acc(1'b1, `SRBC_OFF_BCTL, 32'h11);
    rdx(`SRBC_OFF_BCTL, 32'h11);
    bod_lvl <= 1'b1;
    wt(3);
    bod_lvl <= 1'b0;
    wt(40);
    rdx(`SRBC_OFF_RAW, 32'h0);
    chk(irqw, 32'h0);
    bod_lvl <= 1'b1;
    wt(6);
    rdx(`SRBC_OFF_RAW, 32'h0);
    wt(40);
    rdx(`SRBC_OFF_RAW, 32'h2);
    chk(irqw, 32'h1);
    chk(32'(rst_cnt), 32'h1);
    // Confirmed after the wait, routed to reset this time
    bod_lvl <= 1'b0;
    acc(1'b1, `SRBC_OFF_CLR, 32'h2);
    acc(1'b1, `SRBC_OFF_BCTL, 32'h13);
    bod_lvl <= 1'b1;
    wt(40);
    chk(32'(rst_cnt), 32'h2);
    chk(irqw, 32'h0);
    rdx(`SRBC_OFF_RAW, 32'h2);
    $display("test brown-out done");
    wt(2);
    stop_test();
  end
endmodule
